// ===== src/offset_rewind_read.sv
// offset_rewind_read.sv: fifo read side with offset read-back and rewind to mark
//
// Notes on behaviour
// - 36-bit bus: two enabled offset reads, empty then full, third wraps.
// - 18-bit bus, shallow: two offset reads, empty then full, then wrap.
// - 18-bit bus, deep: empty lsb, empty msb, full lsb, full msb, wrap.
// - 9-bit bus, shallow: four reads lsb/msb per offset, fifth wraps.
// - 9-bit bus, deep: six reads, empty from edge 1, full edge 4, wrap 7.
// - dropping either select or read enable pauses; sequence resumes where it stopped.
// - an offset read overwrites the data word held on the output bus.
// - offset read-back works in standard and fall-through timing alike.
// - standard: mark high with empty flag high enters rewind mode, marks output word.
// - rewind mode lasts until mark sampled low; each new mark replaces the old.
// - in rewind mode, rewind request low returns the read pointer to the mark.
// - standard: empty flag low during rewind setup, high when reads may restart.
// - writes continue, but the write pointer never passes the marked word.
// - fall-through: mark high with output valid low enters mode, marks output word.
// - fall-through: valid drops during setup, marked word loaded when request ends.
// - fall-through: first rewound word appears unread; later words need read enable.
// - offset read needs select and read enable low; reader idles four cycles after each request.
// - master reset puts offset pointer at empty lsb; partial reset leaves it.
// - standard: read pointer stays at mark while rewind request held low.
//
// Our own choices: the pin synchronisers and the configuration wait count.
`timescale 1ns/1ps
`default_nettype none
`include "offset_rewind_map.svh"

module offset_rewind_read
	import offset_rewind_pkg::*;
#(
	parameter int DEPTH = 64,
	parameter int OFS_W = 18
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic read_enable_n,
	input wire logic offset_access_select_n,
	input wire logic mark,
	input wire logic rewind_request_n,
	input wire logic write_enable_n,
	input wire logic [35:0] write_data,
	input wire logic partial_reset_n,
	input wire logic fall_through_mode,
	input wire logic [1:0] out_width_sel,
	input wire logic deep_config,
	input wire logic [OFS_W-1:0] empty_offset,
	input wire logic [OFS_W-1:0] full_offset,
	output logic [35:0] read_data_out,
	output logic empty_indicator_n,
	output logic output_valid_n,
	output logic full_indicator_n,
	output logic retransmit_active
);

	localparam int ADDR_W = $clog2(DEPTH);
	localparam int PTR_W = ADDR_W + 1;
	localparam logic [PTR_W-1:0] DEPTH_P = PTR_W'(DEPTH);

	// depth must be a power of two, offsets must fit three nine-bit parts
	initial
	begin
		if (DEPTH < 2 || (1 << ADDR_W) != DEPTH)
			$error("DEPTH must be a power of two of at least 2");
		if (OFS_W < 1 || OFS_W > 27)
			$error("OFS_W must lie between 1 and 27");
	end

	// idle levels of the pins while reset holds the synchronisers
	localparam pins_t PIN_RST = '{read_enable_n: 1'b1, offset_access_select_n: 1'b1,
		mark: 1'b0, rewind_request_n: 1'b1, write_enable_n: 1'b1, partial_reset_n: 1'b1,
		fall_through_mode: 1'b0, out_width_sel: 2'h0, deep_config: 1'b0, write_data: 36'h0};

	// ==========================================================
	// pin synchronisers
	pins_t pins_raw, p;
	logic [OFS_W-1:0] empty_ofs_s, full_ofs_s;

	assign pins_raw = '{read_enable_n: read_enable_n,
		offset_access_select_n: offset_access_select_n, mark: mark,
		rewind_request_n: rewind_request_n, write_enable_n: write_enable_n,
		partial_reset_n: partial_reset_n, fall_through_mode: fall_through_mode,
		out_width_sel: out_width_sel, deep_config: deep_config, write_data: write_data};

	pin_sync #(
		.W($bits(pins_t)),
		.RST(PIN_RST)
	) u_pin_sync (
		.clk(clk),
		.reset_n(reset_n),
		.d(pins_raw),
		.q(p)
	);

	pin_sync #(
		.W(2 * OFS_W),
		.RST('0)
	) u_ofs_sync (
		.clk(clk),
		.reset_n(reset_n),
		.d({empty_offset, full_offset}),
		.q({empty_ofs_s, full_ofs_s})
	);

	// ==========================================================
	// configuration caught after master reset release
	logic [1:0] cfg_cnt_r;
	logic cfg_done_r, fall_through_mode_r, deep_r;
	out_width_t width_r;

	// straps settle through the synchroniser, then are latched once
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			cfg_cnt_r <= 2'h0;
			cfg_done_r <= 1'b0;
			fall_through_mode_r <= 1'b0;
			width_r <= WIDTH_36;
			deep_r <= 1'b0;
		end
		else if (!cfg_done_r)
		begin
			if (cfg_cnt_r == `CFG_WAIT)
			begin
				cfg_done_r <= 1'b1;
				fall_through_mode_r <= p.fall_through_mode;
				width_r <= (p.out_width_sel == 2'h1) ? WIDTH_18 :
					(p.out_width_sel == 2'h2) ? WIDTH_9 : WIDTH_36;
				deep_r <= p.deep_config;
			end
			else
				cfg_cnt_r <= cfg_cnt_r + 2'h1;
		end
	end

	// ==========================================================
	// offset read-back sequence
	logic [2:0] ofs_idx_r, seq_len, per_ofs;
	logic [35:0] ofs_word;
	logic ofs_rd, fifo_rd_req;

	// an offset read needs both selects low; a fifo read needs select high
	assign ofs_rd = cfg_done_r && !p.offset_access_select_n && !p.read_enable_n;
	assign fifo_rd_req = cfg_done_r && p.offset_access_select_n && !p.read_enable_n;

	// pass length per bus width and depth class
	always_comb
	begin
		unique case (width_r)
			WIDTH_36: seq_len = `SEQ_LEN_36;
			WIDTH_18: seq_len = deep_r ? `SEQ_LEN_18_DEEP : `SEQ_LEN_18_SHALLOW;
			WIDTH_9: seq_len = deep_r ? `SEQ_LEN_9_DEEP : `SEQ_LEN_9_SHALLOW;
		endcase
		per_ofs = seq_len >> 1;
	end

	// part of the selected offset that sits at the current pointer
	function automatic logic [35:0] offset_part(
		input logic [2:0] idx,
		input logic [2:0] per,
		input out_width_t w,
		input logic [OFS_W-1:0] e_ofs,
		input logic [OFS_W-1:0] f_ofs
	);
		logic [35:0] src;
		logic [2:0] part;
		logic [35:0] shifted;
		src = 36'((idx >= per) ? f_ofs : e_ofs);
		part = (idx >= per) ? idx - per : idx;
		shifted = '0;
		// each part is one bus width wide, lowest part first
		unique case (w)
			WIDTH_36: shifted = src;
			WIDTH_18: shifted = {18'h0, 18'(src >> (part * `BUS18_W))};
			WIDTH_9: shifted = {27'h0, 9'(src >> (part * `BUS9_W))};
		endcase
		return shifted;
	endfunction

	assign ofs_word = offset_part(ofs_idx_r, per_ofs, width_r, empty_ofs_s, full_ofs_s);

	// pointer moves only on enabled offset reads; partial reset leaves it
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			ofs_idx_r <= `OFS_IDX_RST;
		else if (ofs_rd)
		begin
			if (ofs_idx_r + 3'h1 >= seq_len)
				ofs_idx_r <= `OFS_IDX_RST;
			else
				ofs_idx_r <= ofs_idx_r + 3'h1;
		end
	end

	// ==========================================================
	// storage and pointers
	logic [35:0] mem_r [DEPTH];
	logic [PTR_W-1:0] wr_r, rd_r, rd_nxt, wr_nxt, mark_r, base, base_nxt;
	logic mode_r, mode_nxt, write_ok, fifo_has, prs;

	assign prs = !p.partial_reset_n;
	assign fifo_has = (wr_r != rd_r);

	// while marked, room is measured from the mark so writes never pass it
	assign base = mode_r ? mark_r : rd_r;
	assign write_ok = cfg_done_r && !p.write_enable_n && ((wr_r - base) != DEPTH_P);
	assign wr_nxt = prs ? '0 : (write_ok ? wr_r + PTR_W'(1) : wr_r);

	// memory written at the write pointer
	always_ff @(posedge clk)
	begin
		if (write_ok && !prs)
			mem_r[wr_r[ADDR_W-1:0]] <= p.write_data;
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			wr_r <= '0;
		else
			wr_r <= wr_nxt;
	end

	// ==========================================================
	// mark tracking
	logic mark_entry;

	// entry condition differs by timing mode
	assign mark_entry = fall_through_mode_r ? !output_valid_n : empty_indicator_n;
	assign mode_nxt = prs ? 1'b0 : (p.mark && (mode_r || (cfg_done_r && mark_entry)));

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			mode_r <= 1'b0;
			mark_r <= '0;
		end
		else
		begin
			mode_r <= mode_nxt;
			// the word now in the output register was read from rd_r - 1
			if (!prs && !mode_r && mode_nxt)
				mark_r <= rd_r - PTR_W'(1);
		end
	end

	// ==========================================================
	// read path and rewind sequencing
	rewind_state_t rw_r, rw_nxt;
	logic [35:0] out_r, out_nxt;
	logic valid_r, valid_nxt;

	always_comb
	begin
		rd_nxt = rd_r;
		out_nxt = out_r;
		valid_nxt = valid_r;
		rw_nxt = rw_r;
		if (prs)
		begin
			rd_nxt = '0;
			out_nxt = `OUT_RST;
			valid_nxt = 1'b0;
			rw_nxt = RW_IDLE;
		end
		else if (rw_r == RW_HOLD)
		begin
			rd_nxt = mark_r;
			if (p.rewind_request_n)
			begin
				rw_nxt = RW_IDLE;
				if (fall_through_mode_r)
				begin
					// first marked word falls through without a read
					out_nxt = mem_r[mark_r[ADDR_W-1:0]];
					rd_nxt = mark_r + PTR_W'(1);
					valid_nxt = 1'b1;
				end
			end
		end
		else if (mode_r && cfg_done_r && !p.rewind_request_n)
		begin
			// reader has already stopped reading here
			rw_nxt = RW_HOLD;
			rd_nxt = mark_r;
			valid_nxt = 1'b0;
		end
		else if (ofs_rd)
		begin
			out_nxt = ofs_word;
			if (fall_through_mode_r)
				valid_nxt = 1'b0;
		end
		else if (!fall_through_mode_r)
		begin
			if (fifo_rd_req && fifo_has)
			begin
				out_nxt = mem_r[rd_r[ADDR_W-1:0]];
				rd_nxt = rd_r + PTR_W'(1);
			end
		end
		else if (!valid_r || fifo_rd_req)
		begin
			if (fifo_has && cfg_done_r)
			begin
				out_nxt = mem_r[rd_r[ADDR_W-1:0]];
				rd_nxt = rd_r + PTR_W'(1);
				valid_nxt = 1'b1;
			end
			else if (fifo_rd_req)
				valid_nxt = 1'b0;
		end
	end

	assign base_nxt = mode_nxt ? (mode_r ? mark_r : rd_r - PTR_W'(1)) : rd_nxt;

	// read-side state
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rd_r <= '0;
			out_r <= `OUT_RST;
			valid_r <= 1'b0;
			rw_r <= RW_IDLE;
		end
		else
		begin
			rd_r <= rd_nxt;
			out_r <= out_nxt;
			valid_r <= valid_nxt;
			rw_r <= rw_nxt;
		end
	end

	// ==========================================================
	// outputs, all from flops
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			read_data_out <= `OUT_RST;
			empty_indicator_n <= 1'b0;
			output_valid_n <= 1'b1;
			full_indicator_n <= 1'b1;
			retransmit_active <= 1'b0;
		end
		else
		begin
			read_data_out <= out_nxt;
			// empty flag low in fall-through or while rewind holds, else low when nothing to read
			empty_indicator_n <= !fall_through_mode_r && (rw_nxt == RW_IDLE)
				&& (wr_nxt != rd_nxt);
			output_valid_n <= !(fall_through_mode_r && valid_nxt);
			full_indicator_n <= ((wr_nxt - base_nxt) != DEPTH_P);
			retransmit_active <= mode_nxt;
		end
	end

endmodule
`default_nettype wire

// ===== src/offset_rewind_map.svh
// offset_rewind_map.svh: offsets, widths, reset values and counts of the read-side block
`ifndef OFFSET_REWIND_MAP_SVH
`define OFFSET_REWIND_MAP_SVH

// data path and offset widths
`define DATA_W 36
`define BUS36_W 36
`define BUS18_W 18
`define BUS9_W 9

// enabled offset read cycles per pass, one per configuration
`define SEQ_LEN_36 3'h2
`define SEQ_LEN_18_SHALLOW 3'h2
`define SEQ_LEN_18_DEEP 3'h4
`define SEQ_LEN_9_SHALLOW 3'h4
`define SEQ_LEN_9_DEEP 3'h6

// reset values and the configuration wait count
`define OFS_IDX_RST 3'h0
`define OUT_RST 36'h0
`define CFG_WAIT 2'h2

`endif

// ===== src/offset_rewind_pkg.sv
// offset_rewind_pkg.sv: types shared by the read-side block
package offset_rewind_pkg;

	// output bus width selection
	typedef enum logic [1:0] {WIDTH_36, WIDTH_18, WIDTH_9} out_width_t;

	// phases of a rewind to the marked word
	typedef enum logic {RW_IDLE, RW_HOLD} rewind_state_t;

	// pin inputs that travel together through the synchroniser
	typedef struct packed {
		logic read_enable_n;
		logic offset_access_select_n;
		logic mark;
		logic rewind_request_n;
		logic write_enable_n;
		logic partial_reset_n;
		logic fall_through_mode;
		logic [1:0] out_width_sel;
		logic deep_config;
		logic [35:0] write_data;
	} pins_t;

endpackage

// ===== src/pin_sync.sv
// pin_sync.sv: two-flop synchroniser for a bus of pin inputs
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST = '0
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] meta_r;

	// first flop feeds only the second
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			meta_r <= RST;
			q <= RST;
		end
		else
		begin
			meta_r <= d;
			q <= meta_r;
		end
	end

endmodule
`default_nettype wire

// ===== dv/offset_rewind_read_properties.sv
// offset_rewind_read_properties.sv: port checks of the read-side block
`timescale 1ns/1ps
`default_nettype none

module offset_rewind_read_properties #(
	parameter int OFS_W = 18
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic read_enable_n,
	input wire logic offset_access_select_n,
	input wire logic mark,
	input wire logic rewind_request_n,
	input wire logic partial_reset_n,
	input wire logic fall_through_mode,
	input wire logic [1:0] out_width_sel,
	input wire logic [OFS_W-1:0] empty_offset,
	input wire logic [OFS_W-1:0] full_offset,
	input wire logic [35:0] read_data_out,
	input wire logic empty_indicator_n,
	input wire logic output_valid_n,
	input wire logic retransmit_active
);
	// ==========
	// pins act three edges after they change
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	// an enabled offset access at the pins
	logic ofs_hit;
	assign ofs_hit = !offset_access_select_n && !read_enable_n;

	offset_wipes_a:
	assert property (fall_through_mode && $past(ofs_hit, 3) |-> output_valid_n)
		else $error("offset read kept a valid word");
	offset_value_a:
	assert property (out_width_sel == 2'h0 && $past(ofs_hit, 3)
		|-> read_data_out[OFS_W-1:0] == empty_offset || read_data_out[OFS_W-1:0] == full_offset)
		else $error("offset read gave no offset");
	pause_hold_a:
	assert property (!fall_through_mode && $past(read_enable_n, 3) && $past(partial_reset_n, 3)
		|-> $stable(read_data_out))
		else $error("bus moved without a read");
	mark_entry_a:
	assert property ($past(mark, 3)
		&& (fall_through_mode ? !$past(output_valid_n) : $past(empty_indicator_n))
		|-> retransmit_active)
		else $error("mark not taken");
	mark_exit_a:
	assert property (!$past(mark, 3) |-> !retransmit_active)
		else $error("mark mode kept");
	rewind_hold_a:
	assert property (!fall_through_mode && $past(retransmit_active) && !$past(rewind_request_n, 3)
		|-> !empty_indicator_n)
		else $error("empty flag high during rewind");
	fall_through_mode_setup_a:
	assert property (fall_through_mode && $past(retransmit_active) && !$past(rewind_request_n, 3)
		|-> output_valid_n)
		else $error("valid low during rewind");
	rewind_done_a:
	assert property ($past(rewind_request_n, 3) && !$past(rewind_request_n, 4)
		&& $past(retransmit_active, 2)
		|-> (fall_through_mode ? !output_valid_n : empty_indicator_n))
		else $error("rewind did not finish");
endmodule

bind offset_rewind_read offset_rewind_read_properties #(.OFS_W(OFS_W))
	i_offset_rewind_read_properties (
		.clk(clk),
		.reset_n(reset_n),
		.read_enable_n(read_enable_n),
		.offset_access_select_n(offset_access_select_n),
		.mark(mark),
		.rewind_request_n(rewind_request_n),
		.partial_reset_n(partial_reset_n),
		.fall_through_mode(fall_through_mode),
		.out_width_sel(out_width_sel),
		.empty_offset(empty_offset),
		.full_offset(full_offset),
		.read_data_out(read_data_out),
		.empty_indicator_n(empty_indicator_n),
		.output_valid_n(output_valid_n),
		.retransmit_active(retransmit_active)
	);

`default_nettype wire

// ===== dv/reader.sv
// reader.sv: reading controller driving the read-side pins
`timescale 1ns/1ps
`default_nettype none

module reader (
	input wire logic clk,
	output logic read_enable_n,
	output logic offset_access_select_n,
	output logic mark,
	output logic rewind_request_n
);
	// ==========
	// pins rest inactive
	initial
	begin
		read_enable_n = 1'b1;
		offset_access_select_n = 1'b1;
		mark = 1'b0;
		rewind_request_n = 1'b1;
	end

	// one request held n cycles, released, then an idle gap
	task automatic req(input logic ren, input logic sel, input logic rt, input int n);
		@(posedge clk);
		read_enable_n <= ren;
		offset_access_select_n <= sel;
		rewind_request_n <= rt;
		repeat (n) @(posedge clk);
		read_enable_n <= 1'b1;
		offset_access_select_n <= 1'b1;
		rewind_request_n <= 1'b1;
		repeat (4) @(posedge clk);
		#1;
	endtask

	// mark level change
	task automatic set_mark(input logic v);
		@(posedge clk);
		mark <= v;
		repeat (4) @(posedge clk);
		#1;
	endtask
endmodule

`default_nettype wire

// ===== dv/offset_rewind_read_test.sv
// offset_rewind_read_test.sv: self-checking bench of the read-side block
`timescale 1ns/1ps
`default_nettype none

module offset_rewind_read_test;
	// ==========
	// stimulus and outputs
	localparam logic [17:0] EOFS = 18'h2A5B3;
	localparam logic [17:0] FOFS = 18'h15C4E;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic write_enable_n = 1'b1;
	logic partial_reset_n = 1'b1;
	logic fall_through_mode = 1'b0;
	logic deep_config = 1'b0;
	logic [1:0] out_width_sel = 2'h0;
	logic [35:0] write_data = 36'h0;
	logic [17:0] empty_offset = EOFS;
	logic [17:0] full_offset = FOFS;
	logic read_enable_n, offset_access_select_n, mark, rewind_request_n;
	logic [35:0] read_data_out;
	logic empty_indicator_n, output_valid_n, full_indicator_n, retransmit_active;
	int err_count = 0;
	int check_count = 0;
	int cyc = 0;

	offset_rewind_read i_offset_rewind_read (
		.clk(clk),
		.reset_n(reset_n),
		.read_enable_n(read_enable_n),
		.offset_access_select_n(offset_access_select_n),
		.mark(mark),
		.rewind_request_n(rewind_request_n),
		.write_enable_n(write_enable_n),
		.write_data(write_data),
		.partial_reset_n(partial_reset_n),
		.fall_through_mode(fall_through_mode),
		.out_width_sel(out_width_sel),
		.deep_config(deep_config),
		.empty_offset(empty_offset),
		.full_offset(full_offset),
		.read_data_out(read_data_out),
		.empty_indicator_n(empty_indicator_n),
		.output_valid_n(output_valid_n),
		.full_indicator_n(full_indicator_n),
		.retransmit_active(retransmit_active)
	);
	reader i_reader (
		.clk(clk),
		.read_enable_n(read_enable_n),
		.offset_access_select_n(offset_access_select_n),
		.mark(mark),
		.rewind_request_n(rewind_request_n)
	);

	// clock and hang guard
	initial
		forever #12.5 clk = ~clk;
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 6000)
		begin
			err_count++;
			results();
		end
	end

	task automatic results();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [35:0] exp, input logic [35:0] got);
		check_count++;
		if (got !== exp)
		begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// ==========
	// bus helpers
	task automatic rst(input logic ftm, input logic [1:0] ows, input logic dp);
		@(posedge clk);
		reset_n <= 1'b0;
		fall_through_mode <= ftm;
		out_width_sel <= ows;
		deep_config <= dp;
		repeat (10) @(posedge clk);
		reset_n <= 1'b1;
		repeat (4) @(posedge clk);
		#1;
	endtask

	task automatic wr(input int n);
		for (int i = 0; i < n; i++)
		begin
			@(posedge clk);
			write_enable_n <= 1'b0;
			write_data <= 36'h100 + 36'(i);
		end
		@(posedge clk);
		write_enable_n <= 1'b1;
		write_data <= 36'hF_FFFF_FFFF;
		repeat (4) @(posedge clk);
		#1;
	endtask

	task automatic prst();
		@(posedge clk);
		partial_reset_n <= 1'b0;
		@(posedge clk);
		partial_reset_n <= 1'b1;
		repeat (4) @(posedge clk);
		#1;
	endtask

	// ==========
	// scenarios
	task automatic t_offsets();
		logic [2:0] len;
		int pw;
		int ix;
		logic [35:0] m;
		logic [35:0] o;
		for (int c = 0; c < 5; c++)
		begin
			rst(c[0], 2'((c + 1) / 2), c == 2 || c == 4);
			len = (c < 2) ? 3'h2 : ((c < 4) ? 3'h4 : 3'h6);
			pw = (c == 0) ? 36 : ((c < 3) ? 18 : 9);
			m = (36'h1 << pw) - 36'h1;
			for (int k = 0; k <= len; k++)
			begin
				if (k == 1)
					prst();
				i_reader.req(1'b0, 1'b0, 1'b1, 1);
				ix = k % len;
				o = {18'h0, (ix < len / 2) ? EOFS : FOFS};
				chk("offset part", (o >> (ix % (len / 2) * pw)) & m, read_data_out & m);
			end
		end
		$display("offsets done");
	endtask

	task automatic t_overwrite();
		for (int f = 0; f < 2; f++)
		begin
			rst(f[0], 2'h0, 1'b0);
			wr(1);
			if (f == 0)
				i_reader.req(1'b0, 1'b1, 1'b1, 1);
			chk("held word", 36'h100, read_data_out);
			i_reader.req(1'b0, 1'b0, 1'b1, 1);
			chk("offset over word", {18'h0, EOFS}, read_data_out);
			chk("word dropped", 36'h1, 36'(output_valid_n));
		end
		$display("overwrite done");
	endtask

	task automatic t_rewind_std();
		rst(1'b0, 2'h0, 1'b0);
		wr(10);
		i_reader.req(1'b0, 1'b1, 1'b1, 1);
		i_reader.set_mark(1'b1);
		chk("mark mode", 36'h1, 36'(retransmit_active));
		i_reader.req(1'b0, 1'b1, 1'b1, 2);
		i_reader.req(1'b1, 1'b1, 1'b0, 5);
		chk("ready after rewind", 36'h1, 36'(empty_indicator_n));
		i_reader.req(1'b0, 1'b1, 1'b1, 1);
		chk("marked word", 36'h100, read_data_out);
		i_reader.set_mark(1'b0);
		chk("mark left", 36'h0, 36'(retransmit_active));
		i_reader.req(1'b0, 1'b1, 1'b1, 1);
		i_reader.set_mark(1'b1);
		i_reader.req(1'b0, 1'b1, 1'b1, 1);
		i_reader.req(1'b1, 1'b1, 1'b0, 2);
		i_reader.req(1'b0, 1'b1, 1'b1, 1);
		chk("new mark", 36'h101, read_data_out);
		i_reader.set_mark(1'b0);
		$display("standard rewind done");
	endtask

	task automatic t_rewind_ft();
		rst(1'b1, 2'h0, 1'b0);
		wr(10);
		chk("first word", 36'h100, read_data_out);
		i_reader.set_mark(1'b1);
		chk("mark mode", 36'h1, 36'(retransmit_active));
		i_reader.req(1'b0, 1'b1, 1'b1, 2);
		chk("two reads", 36'h102, read_data_out);
		i_reader.req(1'b1, 1'b1, 1'b0, 3);
		chk("marked word", 36'h100, read_data_out);
		chk("valid after rewind", 36'h0, 36'(output_valid_n));
		i_reader.req(1'b0, 1'b1, 1'b1, 1);
		chk("next word", 36'h101, read_data_out);
		$display("fall-through rewind done");
	endtask

	// fills up to the mark: the marked word must survive, room returns on exit
	task automatic t_guard();
		wr(60);
		chk("full at mark", 36'h0, 36'(full_indicator_n));
		i_reader.req(1'b1, 1'b1, 1'b0, 2);
		chk("mark kept", 36'h100, read_data_out);
		i_reader.set_mark(1'b0);
		chk("room after mark", 36'h1, 36'(full_indicator_n));
		$display("write guard done");
	endtask

	// main sequence
	initial
	begin
		t_offsets();
		t_overwrite();
		t_rewind_std();
		t_rewind_ft();
		t_guard();
		results();
	end
endmodule

`default_nettype wire
